// file: rtl/profiler_cb_regs.vh
// Purpose: Constants for the profiler control block register file.
// Assumes: Included by the profiler control block modules by bare name.
// Notes: Register offsets are byte addresses of 32-bit words.
`ifndef PROFILER_CB_REGS_VH
`define PROFILER_CB_REGS_VH

`define CB_ADDR_W 8
`define OFF_ENABLE 8'h00
`define OFF_SIZE_JIT 8'h04
`define OFF_BASE_LO 8'h08
`define OFF_BASE_HI 8'h0C
`define OFF_WPTR 8'h10
`define OFF_DROP_LO 8'h18
`define OFF_DROP_HI 8'h1C
`define OFF_ALARM 8'h20
`define OFF_QUAL 8'h24
`define OFF_IPLO_LO 8'h28
`define OFF_IPLO_HI 8'h2C
`define OFF_IPHI_LO 8'h30
`define OFF_IPHI_HI 8'h34
`define OFF_RPTR 8'h40
`define OFF_CTRL 8'h50
`define OFF_STATUS 8'h54
`define OFF_IRQ_STAT 8'h58
`define OFF_IRQ_CLR 8'h5C
`define OFF_IRQ_EN 8'h60
`define OFF_LIN_LO 8'h64
`define OFF_LIN_HI 8'h68
`define OFF_EFF_SIZE 8'h6C
`define SIZE_MSB 27
`define JIT_LSB 28
`define JIT_MSB 31
`define CTRL_LOAD 0
`define CTRL_DISABLE 1
`define CTRL_RECORD 2
`define CTRL_RELOAD 3
`define IRQ_DROP 0
`define IRQ_LOADED 1
`define IRQ_STORED 2
`define RECORD_SIZE 32
`define LFSR_SEED 16'hACE1

`endif

// file: rtl/jitter_reload.v
// Purpose: Reloads an event counter from its interval with random low bits.
// Assumes: Single clock, synchronous active-high reset.
// Notes: A 16-bit LFSR supplies the random bits; period 65535.
`timescale 1ns/1ps
`default_nettype none
`include "profiler_cb_regs.vh"
module jitter_reload #(
  parameter CNT_W = 25
) (
  // Clock and reset.
  input wire clk_sys_i,
  input wire reset_i,
  // Reload request.
  input wire reload_i,
  input wire [CNT_W-1:0] interval_i,
  input wire [3:0] jitter_bits_i,
  // Reloaded counter value.
  output reg [CNT_W-1:0] counter_o
);
  reg [15:0] lfsr_r;
  reg [CNT_W-1:0] mask;
  integer i;
  // Zero-extended so that a counter of any width can take a slice of the LFSR.
  wire [CNT_W+15:0] lfsr_wide = {{CNT_W{1'b0}}, lfsr_r};

  // Mask covers the lowest jitter_bits_i bits; fifteen is the ceiling.
  always @* begin
    mask = {CNT_W{1'b0}};
    for (i = 0; i < 15; i = i + 1) begin
      if (i < jitter_bits_i && i < CNT_W) begin
        mask[i] = 1'b1;
      end
    end
  end

  // LFSR runs freely so the pattern does not lock to the reload rate.
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      lfsr_r <= `LFSR_SEED;
      counter_o <= {CNT_W{1'b0}};
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      if (reload_i) begin
        counter_o <= (interval_i & ~mask) | (lfsr_wide[CNT_W-1:0] & mask);
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/profiler_cb.v
// Purpose: Control block register file and ring-buffer pointer engine.
// Assumes: Software drives the plain register port; one clock.
// Notes: Translation of the base is an identity plus offset input.
`timescale 1ns/1ps
`default_nettype none
`include "profiler_cb_regs.vh"
module profiler_cb #(
  parameter [31:0] FEATURE_BITS = 32'hFFFF_FFFF,
  parameter CNT_W = 25
) (
  // Clock and reset.
  input wire clk_sys_i,
  input wire reset_i,
  // Register port.
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // Address translation and event interface.
  input wire [63:0] seg_base_i,
  input wire [CNT_W-1:0] interval_i,
  output wire [CNT_W-1:0] counter_o,
  output reg [63:0] record_addr_o,
  output wire irq_o
);
  reg [31:0] enable_mask_r;
  reg [31:0] size_jit_r;
  reg [63:0] base_r;
  reg [31:0] wptr_r;
  reg [63:0] drop_r;
  reg [31:0] alarm_r;
  reg [31:0] qual_r;
  reg [63:0] iplo_r;
  reg [63:0] iphi_r;
  reg [31:0] rptr_r;
  reg active_r;
  reg [27:0] eff_size_r;
  reg [63:0] lin_base_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_en_r;
  reg [2:0] ev;
  reg [31:0] wptr_nxt;
  reg [31:0] adv;

  wire wr_ctrl = wr_i && (addr_i == `OFF_CTRL);
  wire do_load = wr_ctrl && wdata_i[`CTRL_LOAD];
  wire do_rec = wr_ctrl && wdata_i[`CTRL_RECORD] && active_r;
  wire do_reload = wr_ctrl && wdata_i[`CTRL_RELOAD] && active_r;
  // Software fields other than the read pointer and IRQ enable and clear are locked while profiling runs.
  wire sw_ok = !active_r;
  // Rounded in a full word, then sliced, so the product never spills into the flop.
  wire [31:0] rounded_size = {4'h0, size_jit_r[`SIZE_MSB:0]} / `RECORD_SIZE * `RECORD_SIZE;

  jitter_reload #(.CNT_W(CNT_W)) u_jit (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .reload_i(do_reload),
    .interval_i(interval_i),
    .jitter_bits_i(size_jit_r[`JIT_MSB:`JIT_LSB]),
    .counter_o(counter_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next write pointer with wrap and full check.
  always @* begin
    adv = wptr_r + `RECORD_SIZE;
    if (adv >= {4'h0, eff_size_r}) begin
      adv = 32'h0000_0000;
    end
    ev = 3'b000;
    wptr_nxt = wptr_r;
    if (do_rec) begin
      ev[`IRQ_STORED] = 1'b1;
      if (adv == rptr_r) begin
        ev[`IRQ_DROP] = 1'b1;
      end else begin
        wptr_nxt = adv;
      end
    end
    if (do_load) begin
      ev[`IRQ_LOADED] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, load op and pointer engine.
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      enable_mask_r <= 32'h0000_0000;
      size_jit_r <= 32'h0000_0000;
      base_r <= 64'h0000_0000_0000_0000;
      wptr_r <= 32'h0000_0000;
      drop_r <= 64'h0000_0000_0000_0000;
      alarm_r <= 32'h0000_0000;
      qual_r <= 32'h0000_0000;
      iplo_r <= 64'h0000_0000_0000_0000;
      iphi_r <= 64'h0000_0000_0000_0000;
      rptr_r <= 32'h0000_0000;
      active_r <= 1'b0;
      eff_size_r <= 28'h000_0000;
      lin_base_r <= 64'h0000_0000_0000_0000;
      irq_stat_r <= 3'b000;
      irq_en_r <= 3'b000;
      record_addr_o <= 64'h0000_0000_0000_0000;
    end else begin
      if (wr_i && sw_ok) begin
        case (addr_i)
          `OFF_ENABLE: enable_mask_r <= wdata_i;
          `OFF_SIZE_JIT: size_jit_r <= wdata_i;
          `OFF_BASE_LO: base_r[31:0] <= wdata_i;
          `OFF_BASE_HI: base_r[63:32] <= wdata_i;
          `OFF_WPTR: wptr_r <= wdata_i;
          `OFF_DROP_LO: drop_r[31:0] <= wdata_i;
          `OFF_DROP_HI: drop_r[63:32] <= wdata_i;
          `OFF_ALARM: alarm_r <= wdata_i;
          `OFF_QUAL: qual_r <= wdata_i;
          `OFF_IPLO_LO: iplo_r[31:0] <= wdata_i;
          `OFF_IPLO_HI: iplo_r[63:32] <= wdata_i;
          `OFF_IPHI_LO: iphi_r[31:0] <= wdata_i;
          `OFF_IPHI_HI: iphi_r[63:32] <= wdata_i;
          default: ;
        endcase
      end
      // Read pointer is software-owned and writable at any time.
      if (wr_i && addr_i == `OFF_RPTR) begin
        rptr_r <= wdata_i;
      end
      if (wr_i && addr_i == `OFF_IRQ_EN) begin
        irq_en_r <= wdata_i[2:0];
      end
      if (do_load) begin
        enable_mask_r <= enable_mask_r & FEATURE_BITS;
        eff_size_r <= rounded_size[`SIZE_MSB:0];
        lin_base_r <= base_r + seg_base_i;
        active_r <= 1'b1;
      end else if (wr_ctrl && wdata_i[`CTRL_DISABLE]) begin
        active_r <= 1'b0;
      end
      if (do_rec) begin
        record_addr_o <= lin_base_r + {32'h0000_0000, wptr_r};
      end
      wptr_r <= (wr_i && sw_ok && addr_i == `OFF_WPTR) ? wdata_i : wptr_nxt;
      if (ev[`IRQ_DROP]) begin
        drop_r <= drop_r + 64'h0000_0000_0000_0001;
      end
      // A new event wins over a clear in the same cycle.
      irq_stat_r <= (irq_stat_r & ~((wr_i && addr_i == `OFF_IRQ_CLR) ? wdata_i[2:0] : 3'b000)) | ev;
    end
  end

  assign irq_o = |(irq_stat_r & irq_en_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped reads return zero.
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        `OFF_ENABLE: rdata_o <= enable_mask_r;
        `OFF_SIZE_JIT: rdata_o <= size_jit_r;
        `OFF_BASE_LO: rdata_o <= base_r[31:0];
        `OFF_BASE_HI: rdata_o <= base_r[63:32];
        `OFF_WPTR: rdata_o <= wptr_r;
        `OFF_DROP_LO: rdata_o <= drop_r[31:0];
        `OFF_DROP_HI: rdata_o <= drop_r[63:32];
        `OFF_ALARM: rdata_o <= alarm_r;
        `OFF_QUAL: rdata_o <= qual_r;
        `OFF_IPLO_LO: rdata_o <= iplo_r[31:0];
        `OFF_IPLO_HI: rdata_o <= iplo_r[63:32];
        `OFF_IPHI_LO: rdata_o <= iphi_r[31:0];
        `OFF_IPHI_HI: rdata_o <= iphi_r[63:32];
        `OFF_RPTR: rdata_o <= rptr_r;
        `OFF_STATUS: rdata_o <= {30'h0000_0000, (wptr_r == rptr_r), active_r};
        `OFF_IRQ_STAT: rdata_o <= {29'h0000_0000, irq_stat_r};
        `OFF_IRQ_EN: rdata_o <= {29'h0000_0000, irq_en_r};
        `OFF_LIN_LO: rdata_o <= lin_base_r[31:0];
        `OFF_LIN_HI: rdata_o <= lin_base_r[63:32];
        `OFF_EFF_SIZE: rdata_o <= {4'h0, eff_size_r};
        default: rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// file: tb/sw_side_model.sv
// Purpose: Software side of the control block: segment base and interval.
// Assumes: Both values stay constant for the whole run.
// Notes: A loader would change them only while profiling is off.
`timescale 1ns/1ps
`default_nettype none
module sw_side_model #(
  parameter CNT_W = 25
) (
  // Values offered to the block.
  output wire [63:0] seg_base_o,
  output wire [CNT_W-1:0] interval_o
);
  // Base is 64-byte aligned with the upper half clear, as for narrow addressing.
  assign seg_base_o = 64'h0000_0000_0000_0040;
  assign interval_o = 25'h1AB_CDEF;
endmodule
`default_nettype wire

// file: tb/profiler_cb_sva.sv
// Purpose: Port-level checks of the profiler control block.
// Assumes: Ring base and segment base are 32-byte aligned.
// Notes: Effects may land one to three cycles after the strobe.
`timescale 1ns/1ps
`default_nettype none
module profiler_cb_sva #(
  parameter CNT_W = 25
) (
  // Clock, reset and register port.
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Event side.
  input wire logic [63:0] seg_base_i,
  input wire logic [CNT_W-1:0] interval_i,
  input wire logic [CNT_W-1:0] counter_o,
  input wire logic [63:0] record_addr_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Decoded control strobes, so each cause is named once.
  wire store_req = wr_i && addr_i == 8'h50 && wdata_i[2];
  wire reload_req = wr_i && addr_i == 8'h50 && wdata_i[3];
  a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data outside read slot");
  a_counter_cause: assert property ($changed(counter_o) |-> $past(reload_req) || $past(reload_req, 2))
    else $error("counter changed without reload");
  a_counter_high: assert property ($changed(counter_o) |-> counter_o[CNT_W-1:15] == interval_i[CNT_W-1:15])
    else $error("counter upper bits differ from interval");
  a_record_cause: assert property ($changed(record_addr_o) |-> $past(store_req) || $past(store_req, 2))
    else $error("record address moved without store");
  a_record_align: assert property ($changed(record_addr_o) |-> record_addr_o[4:0] == 5'h00)
    else $error("record address off slot");
  a_irq_cause: assert property ($rose(irq_o) |-> $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3))
    else $error("interrupt rose without cause");
  a_size_align: assert property ($past(rd_i && addr_i == 8'h6C) |-> rdata_o[4:0] == 5'h00)
    else $error("effective size not record multiple");
  a_wptr_align: assert property ($past(rd_i && addr_i == 8'h10) |-> rdata_o[4:0] == 5'h00)
    else $error("write pointer not record aligned");
endmodule
bind profiler_cb profiler_cb_sva #(.CNT_W(CNT_W)) u_sva (.clk_sys_i, .reset_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .seg_base_i, .interval_i, .counter_o, .record_addr_o, .irq_o);
`default_nettype wire

// file: tb/profiler_cb_tb_top.sv
// Purpose: Self-checking bench of the profiler control block.
// Assumes: Smallest legal ring at 0x1000, segment base 0x40.
// Notes: Outputs are sampled 1 ns after an edge: reads and irq at the updating edge, stores and reloads two edges later.
`timescale 1ns/1ps
`default_nettype none
module profiler_cb_tb_top;
  logic clk_sys_i, reset_i, wr_i, rd_i, irq_o;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [63:0] seg_base, record_addr_o;
  logic [24:0] interval, counter_o;
  int n_mismatch, checks_done;
  // Smallest unit count the core accepts; a plain default, not a measured figure.
  localparam int MIN_RING_UNITS = 1;
  // Smallest ring that software may configure, and its number of record slots.
  localparam int RING_BYTES = 32 * MIN_RING_UNITS * 32;
  localparam int SLOTS = RING_BYTES / 32;
  sw_side_model u_sw (.seg_base_o(seg_base), .interval_o(interval));
  profiler_cb #(.FEATURE_BITS(32'h0000_00F5)) dut (.clk_sys_i, .reset_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .seg_base_i(seg_base), .interval_i(interval), .counter_o,
    .record_addr_o, .irq_o);
  ////////////////////////////////////////////////////////////////////////////////
  // Comparison and bus tasks shared by all scenarios.
  task automatic chk(input string name, input logic [63:0] e, input logic [63:0] got);
    checks_done++;
    if (got !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, e, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string name);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk(name, e, rdata_o);
  endtask
  // One record store, then slot address, pointer and drop count.
  task automatic store(input logic [31:0] slot, input logic [31:0] wp, input logic [31:0] drops);
    wr(8'h50, 32'h0000_0004);
    repeat (2) @(posedge clk_sys_i);
    #1 chk("record_addr", 64'h1040 + slot, record_addr_o);
    rd(8'h10, wp, "write_pointer");
    rd(8'h18, drops, "dropped_lo");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_load;
    wr(8'h00, 32'h0000_00FF);
    wr(8'h04, 32'h3000_0000 | (RING_BYTES + 15));
    wr(8'h08, 32'h0000_1000);
    wr(8'h0C, 32'h0000_0000);
    wr(8'h40, 32'h0000_0000);
    wr(8'h50, 32'h0000_0001);
    rd(8'h00, 32'h0000_00F5, "enable_mask");
    rd(8'h6C, RING_BYTES, "eff_size");
    rd(8'h08, 32'h0000_1000, "base_lo");
    rd(8'h64, 32'h0000_1040, "linear_lo");
    rd(8'h54, 32'h0000_0003, "status");
  endtask
  // Fill to full, overwrite the last slot, then wrap past the end.
  task automatic s_ring;
    for (int i = 0; i < SLOTS - 1; i++) store(32 * i, 32 * (i + 1), 0);
    store(32 * (SLOTS - 1), 32 * (SLOTS - 1), 1);
    wr(8'h40, 32'h0000_0020);
    rd(8'h54, 32'h0000_0001, "status");
    store(32 * (SLOTS - 1), 0, 1);
    store(0, 0, 2);
    rd(8'h40, 32'h0000_0020, "read_pointer");
  endtask
  task automatic s_refuse;
    wr(8'h10, 32'h0000_0080);
    rd(8'h10, 32'h0000_0000, "write_pointer");
    rd(8'h44, 32'h0000_0000, "unmapped");
  endtask
  task automatic s_irq;
    wr(8'h60, 32'h0000_0001);
    #1 chk("irq", 1, irq_o);
    rd(8'h58, 32'h0000_0007, "irq_status");
    wr(8'h5C, 32'h0000_0001);
    #1 chk("irq", 0, irq_o);
    rd(8'h58, 32'h0000_0006, "irq_status");
    wr(8'h60, 32'h0000_0002);
    #1 chk("irq", 1, irq_o);
    wr(8'h60, 32'h0000_0000);
    #1 chk("irq", 0, irq_o);
  endtask
  // Three jitter bits: upper bits follow the interval, low bits must vary.
  task automatic s_reload;
    logic [2:0] first;
    logic varied;
    varied = 1'b0;
    for (int i = 0; i < 8; i++) begin
      wr(8'h50, 32'h0000_0008);
      repeat (2) @(posedge clk_sys_i);
      #1 chk("counter_hi", interval[24:3], counter_o[24:3]);
      if (i == 0) first = counter_o[2:0];
      else if (counter_o[2:0] !== first) varied = 1'b1;
    end
    chk("jitter_varied", 1, varied);
  endtask
  // Stop profiling: stores are ignored and the write pointer opens to software.
  task automatic s_disable;
    wr(8'h50, 32'h0000_0002);
    wr(8'h50, 32'h0000_0004);
    rd(8'h54, 32'h0000_0000, "status");
    rd(8'h18, 32'h0000_0002, "dropped_lo");
    wr(8'h10, 32'h0000_0020);
    rd(8'h54, 32'h0000_0002, "status");
    rd(8'h04, 32'h3000_0000 | (RING_BYTES + 15), "size_field");
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // Reset for six cycles, then the scenarios in order.
  initial begin
    reset_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0000_0000;
    n_mismatch = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    s_load();
    s_ring();
    s_refuse();
    s_irq();
    s_reload();
    s_disable();
    summarize();
  end
endmodule
`default_nettype wire
